/* aw_handler.sv */
// Alarm and warning handler with Wishbone register access
//
// Contract
// - Alarm clears fault-free output and stops motor
// - Warning stops motor only if classed so
// - Stop method follows forced-decel enable
// - Some alarms force dynamic brake regardless
// - Alarm number shown on seven-segment display
// - Warning number shown on seven-segment display
// - Stop method chosen per detected alarm
// - History keeps sixteen most recent alarms
// - Alarm triggers drive recorder capture
// - Analog variant alarm clears both fault outputs
// - Non-stopping warning lets operation continue
// - Stopping warning uses its own stop method
// - Any warning clears warning-free output
// - Stopping warning clears stop-warning-free output
// - Host reads alarm and warning status
// - Error reset or software reset clears alarm
// - Warnings clear automatically or need reset
module aw_handler
#(
   parameter int NUM_W   = aw_pkg::AW_NUM_W,
   parameter int HIST_AW = aw_pkg::AW_HIST_AW
) (
   // Clock and reset
   input  wire logic                             clock_i,
   input  wire logic                             reset_n_i,
   // Wishbone slave
   input  wire logic                             wb_cyc_i,
   input  wire logic                             wb_stb_i,
   input  wire logic                             wb_we_i,
   input  wire logic [aw_pkg::AW_ADDR_W-1:0]     wb_adr_i,
   input  wire logic [aw_pkg::AW_DATA_W/8-1:0]   wb_sel_i,
   input  wire logic [aw_pkg::AW_DATA_W-1:0]     wb_dat_i,
   output logic      [aw_pkg::AW_DATA_W-1:0]     wb_dat_o,
   output logic                                  wb_ack_o,
   // Event reports from detection logic
   input  wire aw_pkg::aw_alarm_s                alarm_i,
   input  wire aw_pkg::aw_warn_s                 warning_i,
   // Output device signals, high when free of the condition
   output logic                                  fault_free_out_o,
   output logic                                  fault_or_warn_free_out_o,
   output logic                                  warning_free_out_o,
   output logic                                  stop_warning_free_out_o,
   // Motor stop request and recorder trigger
   output aw_pkg::aw_stop_s                      stop_o,
   output logic                                  recorder_trigger_o,
   // Seven-segment display, digit 0 is least significant
   output logic [aw_pkg::AW_DIGITS*aw_pkg::AW_SEG_W-1:0] seg_o
);

   import aw_pkg::*;

   localparam int SEG_ALL = AW_DIGITS * AW_SEG_W;

   // Register select from the byte address
   function automatic logic reg_hit(input logic [AW_ADDR_W-1:0] adr,
                                    input logic [AW_ADDR_W-1:0] offs);
      reg_hit = (adr == offs);
   endfunction

   // Bus decode
   // Ack is registered, so a held strobe is answered every other cycle
   wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire bus_wr    = bus_req & wb_we_i;
   wire sel_ctrl  = reg_hit(wb_adr_i, AW_REG_CTRL);
   wire sel_stat  = reg_hit(wb_adr_i, AW_REG_STATUS);
   wire sel_anum  = reg_hit(wb_adr_i, AW_REG_ALARM_NUM);
   wire sel_wnum  = reg_hit(wb_adr_i, AW_REG_WARN_NUM);
   wire sel_hcnt  = reg_hit(wb_adr_i, AW_REG_HIST_COUNT);
   wire sel_hidx  = reg_hit(wb_adr_i, AW_REG_HIST_INDEX);
   wire sel_hdat  = reg_hit(wb_adr_i, AW_REG_HIST_DATA);
   wire wr_ctrl   = bus_wr & sel_ctrl & wb_sel_i[0];
   wire wr_hidx   = bus_wr & sel_hidx & wb_sel_i[0];

   // Command bits act only in their write cycle and read back as zero
   wire err_rst   = wr_ctrl & wb_dat_i[AW_CTRL_ERR_RST];
   wire sw_rst    = wr_ctrl & wb_dat_i[AW_CTRL_SW_RST];
   wire hist_clr  = wr_ctrl & wb_dat_i[AW_CTRL_HIST_CLR];

   // Configuration
   // Only the decel enable and the variant select are stored
   logic cfg_decel_en_reg;
   logic cfg_analog_reg;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_decel_en_reg <= AW_DECEL_EN_RST;
         cfg_analog_reg   <= AW_ANALOG_RST;
      end else if (wr_ctrl) begin
         cfg_decel_en_reg <= wb_dat_i[AW_CTRL_DECEL_EN];
         cfg_analog_reg   <= wb_dat_i[AW_CTRL_ANALOG];
      end
   end

   // Alarm state
   logic             alarm_act_reg;
   logic             alarm_act_next;
   logic [NUM_W-1:0] alarm_num_reg;
   logic [NUM_W-1:0] alarm_num_next;
   aw_stop_method_e  alarm_meth_reg;
   aw_stop_method_e  alarm_meth_next;

   wire alarm_clr = err_rst | sw_rst;
   wire aw_stop_method_e alarm_meth_new =
      aw_pick_method(cfg_decel_en_reg, alarm_i.no_decel);

   // A new alarm wins over a clear arriving in the same cycle
   assign alarm_act_next  = alarm_i.valid | (alarm_act_reg & ~alarm_clr);
   assign alarm_num_next  = alarm_i.valid ? alarm_i.num :
                            (alarm_clr ? '0 : alarm_num_reg);
   assign alarm_meth_next = alarm_i.valid ? alarm_meth_new :
                            (alarm_clr ? AW_STOP_NONE : alarm_meth_reg);

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         alarm_act_reg  <= 1'b0;
         alarm_num_reg  <= '0;
         alarm_meth_reg <= AW_STOP_NONE;
      end else begin
         alarm_act_reg  <= alarm_act_next;
         alarm_num_reg  <= alarm_num_next;
         alarm_meth_reg <= alarm_meth_next;
      end
   end

   // Warning state
   logic             warn_act_reg;
   logic             warn_act_next;
   logic [NUM_W-1:0] warn_num_reg;
   logic [NUM_W-1:0] warn_num_next;
   logic             warn_stop_reg;
   logic             warn_auto_reg;
   aw_stop_method_e  warn_meth_reg;

   // The cause input matters only while a warning is held
   // Auto-clear warnings go when the cause goes; others also need a reset
   wire warn_clr = sw_rst |
                   (~warning_i.cause & (warn_auto_reg | err_rst));
   wire aw_stop_method_e warn_meth_new =
      aw_pick_method(cfg_decel_en_reg, warning_i.no_decel);

   assign warn_act_next = warning_i.valid | (warn_act_reg & ~warn_clr);
   assign warn_num_next = warning_i.valid ? warning_i.num :
                          (warn_clr ? '0 : warn_num_reg);

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         warn_act_reg  <= 1'b0;
         warn_num_reg  <= '0;
         warn_stop_reg <= 1'b0;
         warn_auto_reg <= 1'b0;
         warn_meth_reg <= AW_STOP_NONE;
      end else if (warning_i.valid) begin
         warn_act_reg  <= 1'b1;
         warn_num_reg  <= warning_i.num;
         warn_stop_reg <= warning_i.stops;
         warn_auto_reg <= warning_i.auto_clear;
         warn_meth_reg <= warning_i.stops ? warn_meth_new : AW_STOP_NONE;
      end else if (warn_clr) begin
         warn_act_reg  <= 1'b0;
         warn_num_reg  <= '0;
         warn_stop_reg <= 1'b0;
         warn_auto_reg <= 1'b0;
         warn_meth_reg <= AW_STOP_NONE;
      end
   end

   // Stop and output signal values, taken from next state
   wire warn_stop_next = warning_i.valid ? warning_i.stops :
                         (warn_stop_reg & ~warn_clr);
   wire aw_stop_method_e warn_meth_next =
      warning_i.valid ? (warning_i.stops ? warn_meth_new : AW_STOP_NONE) :
      (warn_clr ? AW_STOP_NONE : warn_meth_reg);

   // A non-stopping warning leaves the stop request low
   wire stop_req_next = alarm_act_next | (warn_act_next & warn_stop_next);
   wire aw_stop_method_e stop_meth_next =
      alarm_act_next ? alarm_meth_next :
      (warn_stop_next ? warn_meth_next : AW_STOP_NONE);

   wire fault_free_next  = ~alarm_act_next;
   wire warn_free_next   = ~warn_act_next;
   wire wstop_free_next  = ~(warn_act_next & warn_stop_next);
   wire fowf_next        = cfg_analog_reg ?
                           ~(alarm_act_next | warn_act_next) : 1'b1;

   // Display shows the alarm first, otherwise the warning
   wire             disp_on  = alarm_act_next | warn_act_next;
   wire [NUM_W-1:0] disp_num = alarm_act_next ? alarm_num_next : warn_num_next;
   wire [SEG_ALL-1:0] seg_next;

   // Digit g shows nibble g of the number; all digits blank while idle
   genvar g;
   generate
      for (g = 0; g < AW_DIGITS; g++) begin : g_digit
         assign seg_next[g*AW_SEG_W +: AW_SEG_W] =
            disp_on ? aw_hex_to_seg(disp_num[g*AW_NIBBLE_W +: AW_NIBBLE_W]) : '0;
      end
   endgenerate

   // Pin-level outputs come from flip-flops so they cannot glitch
   aw_stop_s stop_reg;
   logic     fault_free_reg;
   logic     fowf_reg;
   logic     warn_free_reg;
   logic     wstop_free_reg;
   logic     rec_trig_reg;
   logic [SEG_ALL-1:0] seg_reg;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stop_reg       <= '{req: 1'b0, method: AW_STOP_NONE};
         fault_free_reg <= 1'b1;
         fowf_reg       <= 1'b1;
         warn_free_reg  <= 1'b1;
         wstop_free_reg <= 1'b1;
         rec_trig_reg   <= 1'b0;
         seg_reg        <= '0;
      end else begin
         stop_reg       <= '{req: stop_req_next, method: stop_meth_next};
         fault_free_reg <= fault_free_next;
         fowf_reg       <= fowf_next;
         warn_free_reg  <= warn_free_next;
         wstop_free_reg <= wstop_free_next;
         rec_trig_reg   <= alarm_i.valid;
         seg_reg        <= seg_next;
      end
   end

   assign stop_o                   = stop_reg;
   assign fault_free_out_o         = fault_free_reg;
   assign fault_or_warn_free_out_o = fowf_reg;
   assign warning_free_out_o       = warn_free_reg;
   assign stop_warning_free_out_o  = wstop_free_reg;
   assign recorder_trigger_o       = rec_trig_reg;
   assign seg_o                    = seg_reg;

   // Alarm history ring
   // Memory contents survive reset; the count keeps stale entries hidden
   logic [HIST_AW-1:0] wr_ptr_reg;
   logic [HIST_AW:0]   hist_cnt_reg;
   logic [HIST_AW-1:0] hist_idx_reg;
   logic               hist_valid_reg;
   logic [NUM_W-1:0]   hist_rdata;

   localparam logic [HIST_AW:0] HIST_FULL = (HIST_AW+1)'(2**HIST_AW);

   // A clear in the same cycle as an alarm leaves that alarm as sole entry
   wire [HIST_AW-1:0] base_ptr = hist_clr ? '0 : wr_ptr_reg;
   wire [HIST_AW:0]   base_cnt = hist_clr ? '0 : hist_cnt_reg;
   // Index 0 is the newest entry
   wire [HIST_AW-1:0] rd_addr  = wr_ptr_reg - hist_idx_reg - 1'b1;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_reg   <= '0;
         hist_cnt_reg <= '0;
      end else if (alarm_i.valid) begin
         wr_ptr_reg   <= base_ptr + 1'b1;
         hist_cnt_reg <= (base_cnt == HIST_FULL) ? HIST_FULL : base_cnt + 1'b1;
      end else begin
         wr_ptr_reg   <= base_ptr;
         hist_cnt_reg <= base_cnt;
      end
   end

   // Valid flag is delayed like the memory read so both line up
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hist_idx_reg   <= '0;
         hist_valid_reg <= 1'b0;
      end else begin
         if (wr_hidx) begin
            hist_idx_reg <= wb_dat_i[HIST_AW-1:0];
         end
         hist_valid_reg <= ({1'b0, hist_idx_reg} < hist_cnt_reg);
      end
   end

   aw_hist_mem #(
      .WIDTH (NUM_W),
      .AW    (HIST_AW)
   ) u_hist_mem (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .wr_en_i   (alarm_i.valid),
      .wr_addr_i (base_ptr),
      .wr_data_i (alarm_i.num),
      .rd_addr_i (rd_addr),
      .rd_data_o (hist_rdata)
   );

   // Read data selection
   logic [AW_DATA_W-1:0] ctrl_word;
   logic [AW_DATA_W-1:0] stat_word;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[AW_CTRL_DECEL_EN] = cfg_decel_en_reg;
      ctrl_word[AW_CTRL_ANALOG]   = cfg_analog_reg;
      stat_word = '0;
      stat_word[AW_STAT_ALARM]    = alarm_act_reg;
      stat_word[AW_STAT_WARN]     = warn_act_reg;
      stat_word[AW_STAT_WSTOP]    = warn_stop_reg;
      stat_word[AW_STAT_STOP_REQ] = stop_reg.req;
      stat_word[AW_STAT_METHOD_LSB +: $bits(aw_stop_method_e)] = stop_reg.method;
      stat_word[AW_STAT_WAUTO]    = warn_auto_reg;
   end

   // Unmapped addresses read as zero and are still acknowledged
   wire [AW_DATA_W-1:0] rd_word =
      sel_ctrl ? ctrl_word :
      sel_stat ? stat_word :
      sel_anum ? AW_DATA_W'(alarm_num_reg) :
      sel_wnum ? AW_DATA_W'(warn_num_reg) :
      sel_hcnt ? AW_DATA_W'(hist_cnt_reg) :
      sel_hidx ? AW_DATA_W'(hist_idx_reg) :
      (sel_hdat & hist_valid_reg) ? AW_DATA_W'(hist_rdata) : '0;

   // Read data is latched only for reads and held until the next one
   logic                 ack_reg;
   logic [AW_DATA_W-1:0] dat_reg;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end else begin
         ack_reg <= bus_req;
         if (bus_req & ~wb_we_i) begin
            dat_reg <= rd_word;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

endmodule

/* aw_pkg.sv */
// Constants, types and helper functions of the alarm and warning handler
package aw_pkg;

   localparam int AW_DATA_W     = 32;
   localparam int AW_ADDR_W     = 8;
   localparam int AW_NUM_W      = 16;
   localparam int AW_HIST_AW    = 4;
   localparam int AW_DIGITS     = 4;
   localparam int AW_SEG_W      = 7;
   localparam int AW_NIBBLE_W   = 4;

   // Register byte addresses
   localparam logic [AW_ADDR_W-1:0] AW_REG_CTRL       = 8'h00;
   localparam logic [AW_ADDR_W-1:0] AW_REG_STATUS     = 8'h04;
   localparam logic [AW_ADDR_W-1:0] AW_REG_ALARM_NUM  = 8'h08;
   localparam logic [AW_ADDR_W-1:0] AW_REG_WARN_NUM   = 8'h0C;
   localparam logic [AW_ADDR_W-1:0] AW_REG_HIST_COUNT = 8'h10;
   localparam logic [AW_ADDR_W-1:0] AW_REG_HIST_INDEX = 8'h14;
   localparam logic [AW_ADDR_W-1:0] AW_REG_HIST_DATA  = 8'h18;

   // Control register bits
   localparam int AW_CTRL_DECEL_EN = 0;
   localparam int AW_CTRL_ANALOG   = 1;
   localparam int AW_CTRL_ERR_RST  = 2;
   localparam int AW_CTRL_SW_RST   = 3;
   localparam int AW_CTRL_HIST_CLR = 4;

   // Status register bits
   localparam int AW_STAT_ALARM      = 0;
   localparam int AW_STAT_WARN       = 1;
   localparam int AW_STAT_WSTOP      = 2;
   localparam int AW_STAT_STOP_REQ   = 3;
   localparam int AW_STAT_METHOD_LSB = 4;
   localparam int AW_STAT_WAUTO      = 6;

   // Reset values
   localparam logic AW_DECEL_EN_RST = 1'b0;
   localparam logic AW_ANALOG_RST   = 1'b0;

   typedef enum logic [1:0] {
      AW_STOP_NONE  = 2'b00,
      AW_STOP_DECEL = 2'b01,
      AW_STOP_DYNBR = 2'b10
   } aw_stop_method_e;

   // Alarm report from the detection logic
   typedef struct packed {
      logic                valid;
      logic [AW_NUM_W-1:0] num;
      logic                no_decel;
   } aw_alarm_s;

   // Warning report from the detection logic
   typedef struct packed {
      logic                valid;
      logic [AW_NUM_W-1:0] num;
      logic                stops;
      logic                no_decel;
      logic                auto_clear;
      logic                cause;
   } aw_warn_s;

   // Stop request toward the motor control
   typedef struct packed {
      logic            req;
      aw_stop_method_e method;
   } aw_stop_s;

   function automatic aw_stop_method_e aw_pick_method(input logic decel_en,
                                                      input logic no_decel);
      aw_pick_method = (decel_en && !no_decel) ? AW_STOP_DECEL : AW_STOP_DYNBR;
   endfunction

   // Segment order gfedcba, segment lit when high
   function automatic logic [AW_SEG_W-1:0] aw_hex_to_seg(input logic [AW_NIBBLE_W-1:0] d);
      case (d)
         4'h0:    aw_hex_to_seg = 7'h3F;
         4'h1:    aw_hex_to_seg = 7'h06;
         4'h2:    aw_hex_to_seg = 7'h5B;
         4'h3:    aw_hex_to_seg = 7'h4F;
         4'h4:    aw_hex_to_seg = 7'h66;
         4'h5:    aw_hex_to_seg = 7'h6D;
         4'h6:    aw_hex_to_seg = 7'h7D;
         4'h7:    aw_hex_to_seg = 7'h07;
         4'h8:    aw_hex_to_seg = 7'h7F;
         4'h9:    aw_hex_to_seg = 7'h6F;
         4'hA:    aw_hex_to_seg = 7'h77;
         4'hB:    aw_hex_to_seg = 7'h7C;
         4'hC:    aw_hex_to_seg = 7'h39;
         4'hD:    aw_hex_to_seg = 7'h5E;
         4'hE:    aw_hex_to_seg = 7'h79;
         default: aw_hex_to_seg = 7'h71;
      endcase
   endfunction

endpackage

/* aw_hist_mem.sv */
// Alarm history storage with registered read data
module aw_hist_mem #(
   parameter int WIDTH = 16,
   parameter int AW    = 4
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             reset_n_i,
   // Write port
   input  wire logic             wr_en_i,
   input  wire logic [AW-1:0]    wr_addr_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   // Read port
   input  wire logic [AW-1:0]    rd_addr_i,
   output logic      [WIDTH-1:0] rd_data_o
);

   logic [WIDTH-1:0] mem [2**AW];
   logic [WIDTH-1:0] rd_data_reg;

   always_ff @(posedge clock_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_reg <= '0;
      end else begin
         rd_data_reg <= mem[rd_addr_i];
      end
   end

   assign rd_data_o = rd_data_reg;

endmodule

/* aw_handler_sva.sv */
// Port-level checker for the alarm and warning handler
module aw_handler_sva
   import aw_pkg::*;
(
   input wire logic                   clock_i,
   input wire logic                   reset_n_i,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_we_i,
   input wire logic [AW_ADDR_W-1:0]   wb_adr_i,
   input wire logic [AW_DATA_W/8-1:0] wb_sel_i,
   input wire logic [AW_DATA_W-1:0]   wb_dat_i,
   input wire logic                   wb_ack_o,
   input wire aw_alarm_s              alarm_i,
   input wire aw_warn_s               warning_i,
   input wire logic                   fault_free_out_o,
   input wire logic                   fault_or_warn_free_out_o,
   input wire logic                   warning_free_out_o,
   input wire logic                   stop_warning_free_out_o,
   input wire aw_stop_s               stop_o,
   input wire logic                   recorder_trigger_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic decel_q;
   logic analog_q;
   // Control write taken at this edge
   wire  ctrl_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == AW_REG_CTRL
                  && wb_sel_i[0];
   wire  clr_w  = ctrl_w && (wb_dat_i[AW_CTRL_ERR_RST] || wb_dat_i[AW_CTRL_SW_RST]);
   wire  pick_w = decel_q && !alarm_i.no_decel;
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         decel_q  <= AW_DECEL_EN_RST;
         analog_q <= AW_ANALOG_RST;
      end else if (ctrl_w) begin
         decel_q  <= wb_dat_i[AW_CTRL_DECEL_EN];
         analog_q <= wb_dat_i[AW_CTRL_ANALOG];
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   sequence s_stopped;
      !fault_free_out_o && stop_o.req;
   endsequence
   a_alarm_stops: assert property (alarm_i.valid |=> s_stopped)
      else $error("alarm did not stop motor");
   a_trig_pulse: assert property (recorder_trigger_o == $past(alarm_i.valid))
      else $error("recorder trigger mismatch");
   a_warn_flag: assert property (warning_i.valid |=> !warning_free_out_o)
      else $error("warning output still free");
   a_wstop_flag: assert property (warning_i.valid && warning_i.stops
      |=> !stop_warning_free_out_o && stop_o.req) else $error("stopping warning ignored");
   a_warn_runs: assert property (warning_i.valid && !warning_i.stops && !alarm_i.valid
      && !stop_o.req |=> !stop_o.req) else $error("plain warning stopped motor");
   a_alarm_method: assert property (alarm_i.valid && !warning_i.valid
      |=> stop_o.method == ($past(pick_w) ? AW_STOP_DECEL : AW_STOP_DYNBR))
      else $error("wrong stop method");
   a_alarm_hold: assert property (!fault_free_out_o && !clr_w |=> !fault_free_out_o)
      else $error("alarm released without reset");
   a_alarm_clear: assert property (clr_w && !alarm_i.valid |=> fault_free_out_o)
      else $error("alarm not cleared by reset");
   a_analog_both: assert property (alarm_i.valid && analog_q
      |=> !fault_or_warn_free_out_o) else $error("combined output still free");
   a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse)
      else $error("bus answer missing");
endmodule
bind aw_handler aw_handler_sva u_sva (.*);

/* aw_host.sv */
// Host controller model issuing Wishbone register cycles
module aw_host
   import aw_pkg::*;
(
   input  wire logic                   clock_i,
   input  wire logic                   ack_i,
   input  wire logic [AW_DATA_W-1:0]   dat_i,
   output logic                        cyc_o,
   output logic                        stb_o,
   output logic                        we_o,
   output logic [AW_ADDR_W-1:0]        adr_o,
   output logic [AW_DATA_W/8-1:0]      sel_o,
   output logic [AW_DATA_W-1:0]        dat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // Request held until the edge that sees ack high
   task automatic xfer(input logic w, input logic [AW_ADDR_W-1:0] a,
                       input logic [AW_DATA_W-1:0] d, output logic [AW_DATA_W-1:0] q);
      @(posedge clock_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= 4'hF;
      dat_o <= d;
      wait (ack_i === 1'b1);
      @(posedge clock_i);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o  <= 1'b0;
      @(posedge clock_i);
   endtask
endmodule

/* aw_handler_tb_top.sv */
// Self-checking bench of the alarm and warning handler
module aw_handler_tb_top;
   import aw_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0] ctrl; logic w; logic [15:0] num; logic st; logic nd; aw_stop_method_e em;
   } aw_row_s;
   localparam logic [6:0] SG [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
      7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
   aw_row_s rows [7] = '{'{2'h1, 1'b0, 16'h0037, 1'b0, 1'b0, AW_STOP_DECEL},
      '{2'h1, 1'b0, 16'h0A1F, 1'b0, 1'b1, AW_STOP_DYNBR},
      '{2'h0, 1'b0, 16'h0B5E, 1'b0, 1'b0, AW_STOP_DYNBR},
      '{2'h3, 1'b0, 16'h0C2D, 1'b0, 1'b0, AW_STOP_DECEL},
      '{2'h1, 1'b1, 16'h0E91, 1'b1, 1'b0, AW_STOP_DECEL},
      '{2'h2, 1'b1, 16'h0E92, 1'b0, 1'b0, AW_STOP_NONE},
      '{2'h0, 1'b1, 16'h0F48, 1'b1, 1'b0, AW_STOP_DYNBR}};
   logic clock_i, reset_n_i, cyc, stb, we, ack, ff, fw, wf, sw, trig;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, d;
   logic [27:0] seg;
   aw_alarm_s alarm_i;
   aw_warn_s warning_i;
   aw_stop_s stop;
   aw_row_s r;
   int miscompares = 0;
   int n_tests = 0;
   aw_handler u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .alarm_i(alarm_i), .warning_i(warning_i), .fault_free_out_o(ff),
      .fault_or_warn_free_out_o(fw), .warning_free_out_o(wf), .stop_warning_free_out_o(sw),
      .stop_o(stop), .recorder_trigger_o(trig), .seg_o(seg));
   aw_host u_host (.clock_i(clock_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   function automatic logic [27:0] segs(input logic [15:0] n);
      for (int i = 0; i < 4; i++) segs[i*7+:7] = SG[n[i*4+:4]];
   endfunction
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wrap_up;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   initial begin
      #100000;
      miscompares++;
      wrap_up();
   end
   initial begin
      reset_n_i = 1'b0;
      alarm_i = '0;
      warning_i = '0;
      repeat (4) @(posedge clock_i);
      chk_word({25'h0, ff, fw, wf, sw, stop.req, trig, ack}, 32'h78);
      chk_word({4'h0, seg}, 32'h0);
      reset_n_i <= 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         u_host.xfer(1'b1, AW_REG_CTRL, {30'h0, r.ctrl}, d);
         if (r.w) warning_i <= '{1'b1, r.num, r.st, r.nd, 1'b0, 1'b1};
         else alarm_i <= '{1'b1, r.num, r.nd};
         @(posedge clock_i);
         alarm_i.valid <= 1'b0;
         warning_i.valid <= 1'b0;
         #1;
         chk_bit(ff, r.w);
         chk_bit(fw, !r.ctrl[1]);
         chk_bit(wf, !r.w);
         chk_bit(sw, !(r.w && r.st));
         chk_bit(stop.req, !r.w || r.st);
         if (!r.w || r.st) chk_word({30'h0, stop.method}, {30'h0, r.em});
         chk_bit(trig, !r.w);
         chk_word({4'h0, seg}, {4'h0, segs(r.num)});
         u_host.xfer(1'b0, AW_REG_STATUS, 32'h0, d);
         chk_word({30'h0, d[1:0]}, {30'h0, r.w, !r.w});
         u_host.xfer(1'b0, r.w ? AW_REG_WARN_NUM : AW_REG_ALARM_NUM, 32'h0, d);
         chk_word(d, {16'h0, r.num});
         warning_i.cause <= 1'b0;
         repeat (2) @(posedge clock_i);
         #1;
         chk_bit(wf, !r.w);
         u_host.xfer(1'b1, AW_REG_CTRL, {29'h0, 1'b1, r.ctrl}, d);
         #1;
         chk_word({29'h0, ff, wf, stop.req}, 32'h6);
         u_host.xfer(1'b0, AW_REG_STATUS, 32'h0, d);
         chk_word({28'h0, d[3:0]}, 32'h0);
      end
      u_host.xfer(1'b1, AW_REG_CTRL, 32'h11, d);
      for (int i = 0; i < 17; i++) begin
         alarm_i <= '{1'b1, 16'(16'h0100 + i), 1'b0};
         @(posedge clock_i);
      end
      alarm_i.valid <= 1'b0;
      u_host.xfer(1'b0, AW_REG_HIST_COUNT, 32'h0, d);
      chk_word(d, 32'h10);
      u_host.xfer(1'b1, AW_REG_HIST_INDEX, 32'h0, d);
      u_host.xfer(1'b0, AW_REG_HIST_DATA, 32'h0, d);
      chk_word(d, 32'h0110);
      u_host.xfer(1'b1, AW_REG_HIST_INDEX, 32'hF, d);
      u_host.xfer(1'b0, AW_REG_HIST_DATA, 32'h0, d);
      chk_word(d, 32'h0101);
      warning_i <= '{1'b1, 16'h0E01, 1'b0, 1'b0, 1'b1, 1'b1};
      @(posedge clock_i);
      warning_i.valid <= 1'b0;
      #1;
      chk_word({4'h0, seg}, {4'h0, segs(16'h0110)});
      chk_bit(wf, 1'b0);
      @(posedge clock_i);
      warning_i.cause <= 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      chk_bit(wf, 1'b1);
      chk_bit(ff, 1'b0);
      u_host.xfer(1'b1, AW_REG_CTRL, 32'h8, d);
      #1;
      chk_bit(ff, 1'b1);
      chk_word({4'h0, seg}, 32'h0);
      @(posedge clock_i);
      alarm_i <= '{1'b1, 16'h0D21, 1'b0};
      @(posedge clock_i);
      alarm_i.valid <= 1'b0;
      #1;
      chk_bit(ff, 1'b0);
      @(posedge clock_i);
      reset_n_i <= 1'b0;
      @(posedge clock_i);
      #1;
      chk_word({25'h0, ff, fw, wf, sw, stop.req, trig, ack}, 32'h78);
      chk_word({4'h0, seg}, 32'h0);
      @(posedge clock_i);
      reset_n_i <= 1'b1;
      u_host.xfer(1'b0, AW_REG_HIST_COUNT, 32'h0, d);
      chk_word(d, 32'h0);
      u_host.xfer(1'b0, AW_REG_HIST_DATA, 32'h0, d);
      chk_word(d, 32'h0);
      u_host.xfer(1'b0, 8'hFC, 32'h0, d);
      chk_word(d, 32'h0);
      wrap_up();
   end
endmodule
